//--- hw/sio_pkg.sv
// constants, register map and carrier types for the shared i/o port
// How it works
// - An enabled peripheral that actively drives a pin takes the driver; pin stays readable.
// - An enabled but idle peripheral leaves the pin to latch and direction.
// - Peripheral inputs never see a level the port itself is driving.
// - Direction bit 1 makes the pin an input, 0 makes it a driven output.
// - Every reset sets all implemented direction bits, so all pins start as inputs.
// - The latch register reads back the stored latch and writes update it.
// - The pin register reads sampled pin levels; writes to it land in the latch.
// - Unimplemented bits are disabled and read zero in latch, direction and pin.
// - An open-drain bit makes the pin pull low only; clear means push-pull.
// - Pin register reads return zero for pins set as analog inputs.
// - A change on an enabled watched input raises an interrupt request.
// - Up to 21 watched change inputs are supported.
// - Each watched input has its own enable bit across two enable registers.
// - Each watched input has its own weak pull-up enable across two registers.
// - Pins shared only with input functions are driven by the port alone.
// - Peripheral inputs can be routed from any pin of the port by software.
// - A lock with an unlock key sequence guards the peripheral routing.
package sio_pkg;
  // ***************************************************
  // widths
  // ***************************************************
  localparam int PIN_W   = 16;  // port width
  localparam int CN_W    = 21;  // change watch inputs
  localparam int CN_LO_W = 16;  // bits held by the low enable/pull-up registers
  localparam int CN_HI_W = 5;   // bits held by the high registers
  localparam int MAP_N   = 4;   // routed peripheral inputs
  localparam int MAP_FW  = 5;   // width of one routing field
  localparam int ADR_W   = 8;
  // ***************************************************
  // register byte offsets
  // ***************************************************
  localparam logic [ADR_W-1:0] PORT_DIRECTION_OFS   = 8'h00;
  localparam logic [ADR_W-1:0] OUTPUT_LATCH_OFS     = 8'h04;
  localparam logic [ADR_W-1:0] PIN_LEVEL_OFS        = 8'h08;
  localparam logic [ADR_W-1:0] OPEN_DRAIN_OFS       = 8'h0C;
  localparam logic [ADR_W-1:0] ANALOG_CFG_OFS       = 8'h10;
  localparam logic [ADR_W-1:0] CHG_EN_LO_OFS        = 8'h14;
  localparam logic [ADR_W-1:0] CHG_EN_HI_OFS        = 8'h18;
  localparam logic [ADR_W-1:0] PULLUP_LO_OFS        = 8'h1C;
  localparam logic [ADR_W-1:0] PULLUP_HI_OFS        = 8'h20;
  localparam logic [ADR_W-1:0] CHG_STATUS_OFS       = 8'h24;
  localparam logic [ADR_W-1:0] INPUT_MAP_OFS        = 8'h28;
  localparam logic [ADR_W-1:0] MAP_LOCK_OFS         = 8'h2C;
  // ***************************************************
  // fields and reset values
  // ***************************************************
  localparam int CHG_FLAG_BIT  = 0;  // status: sticky change flag, write 1 to clear
  localparam int LOCK_BIT      = 0;  // lock register: 1 = routing locked
  localparam logic [PIN_W-1:0] DIR_RST   = 16'hFFFF;
  localparam logic [PIN_W-1:0] ZERO16    = 16'h0000;
  localparam logic [MAP_N*MAP_FW-1:0] MAP_RST = 20'h00000;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
  localparam logic       LOCK_RST    = 1'b0;
  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [1:0] {LK_IDLE, LK_KEY1, LK_OPEN} sio_lock_state_type;
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } sio_wb_req_type;
  typedef struct packed {
    logic [PIN_W-1:0] o;     // level driven when enabled
    logic [PIN_W-1:0] oe_n;  // low while driving
  } sio_pad_out_type;
endpackage

//--- hw/sio_port.sv
// shared parallel i/o port with change watch and peripheral input routing
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sio_port #(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF  // implemented port bits of this variant
) (
  input  wire logic                   clock_i,          // 40 MHz system clock
  input  wire logic                   resetn_i,         // async reset, active low
  input  wire sio_pkg::sio_wb_req_type wb_req_i,        // wishbone request bundle
  output logic                        wb_ack_o,         // wishbone ack
  output logic [31:0]                 wb_dat_o,         // wishbone read data
  input  wire logic [15:0]            pad_i,            // pin levels
  output sio_pkg::sio_pad_out_type    pad_o,            // pin drive and enables
  input  wire logic [15:0]            periph_en_i,      // peripheral enabled on pin
  input  wire logic [15:0]            periph_drive_i,   // peripheral actively driving
  input  wire logic [15:0]            periph_out_i,     // peripheral output level
  output logic [3:0]                  periph_in_o,      // routed peripheral inputs
  input  wire logic [20:0]            change_watch_input_i, // watched inputs
  output logic [20:0]                 pullup_en_o,      // weak pull-up enables
  output logic                        change_irq_o      // change interrupt request
);
  // ***************************************************
  // registers
  // ***************************************************
  logic [15:0] port_direction_reg_r;
  logic [15:0] output_latch_reg_r;
  logic [15:0] pin_level_reg_r;
  logic [15:0] open_drain_select_reg_r;
  logic [15:0] analog_pin_config_reg_r;
  logic [15:0] change_irq_enable_lo_r;
  logic [4:0]  change_irq_enable_hi_r;
  logic [15:0] weak_pullup_enable_lo_r;
  logic [4:0]  weak_pullup_enable_hi_r;
  logic [19:0] input_map_r;
  logic        map_lock_r;
  sio_pkg::sio_lock_state_type lock_st_r;
  sio_pkg::sio_lock_state_type lock_st_nxt;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [20:0] cn_s1_r;
  logic [20:0] cn_s2_r;
  logic [20:0] cn_prev_r;
  logic        chg_flag_r;
  logic [15:0] pad_val_r;
  logic [15:0] pad_oe_n_r;
  logic [3:0]  periph_in_r;

  // ***************************************************
  // bus decode
  // ***************************************************
  logic        req;
  logic        wr;
  logic        rd;
  logic [20:0] enables;
  logic        mismatch;
  logic        clr_flag;
  logic [15:0] periph_act;
  logic [15:0] port_drive;
  logic [15:0] drive;
  logic [15:0] val;

  // byte-lane merge for the 16-bit registers
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = nw[7:0];
    end
    if (sel[1]) begin
      res[15:8] = nw[15:8];
    end
    return res;
  endfunction

  function automatic logic [19:0] wmerge20(input logic [19:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [19:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = nw[7:0];
    end
    if (sel[1]) begin
      res[15:8] = nw[15:8];
    end
    if (sel[2]) begin
      res[19:16] = nw[19:16];
    end
    return res;
  endfunction

  // a request is served once; ack drops the cycle after it was given
  assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
  assign wr  = req & wb_req_i.we;
  assign rd  = req & ~wb_req_i.we;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // read mux; unmapped offsets read zero and still ack
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dat_r <= 32'h00000000;
    end else if (rd) begin
      case (wb_req_i.adr)
        sio_pkg::PORT_DIRECTION_OFS: dat_r <= {16'h0000, port_direction_reg_r & IMPL_MASK};
        sio_pkg::OUTPUT_LATCH_OFS:   dat_r <= {16'h0000, output_latch_reg_r & IMPL_MASK};
        sio_pkg::PIN_LEVEL_OFS:      dat_r <= {16'h0000, pin_level_reg_r & ~analog_pin_config_reg_r & IMPL_MASK};
        sio_pkg::OPEN_DRAIN_OFS:     dat_r <= {16'h0000, open_drain_select_reg_r};
        sio_pkg::ANALOG_CFG_OFS:     dat_r <= {16'h0000, analog_pin_config_reg_r};
        sio_pkg::CHG_EN_LO_OFS:      dat_r <= {16'h0000, change_irq_enable_lo_r};
        sio_pkg::CHG_EN_HI_OFS:      dat_r <= {27'h0000000, change_irq_enable_hi_r};
        sio_pkg::PULLUP_LO_OFS:      dat_r <= {16'h0000, weak_pullup_enable_lo_r};
        sio_pkg::PULLUP_HI_OFS:      dat_r <= {27'h0000000, weak_pullup_enable_hi_r};
        sio_pkg::CHG_STATUS_OFS:     dat_r <= {31'h00000000, chg_flag_r};
        sio_pkg::INPUT_MAP_OFS:      dat_r <= {12'h000, input_map_r};
        sio_pkg::MAP_LOCK_OFS:       dat_r <= {30'h00000000, lock_st_r == sio_pkg::LK_OPEN, map_lock_r};
        default:                     dat_r <= 32'h00000000;
      endcase
    end
  end

  // ***************************************************
  // port control registers
  // ***************************************************
  // direction comes up all inputs; unimplemented bits stay zero
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_direction_reg_r <= sio_pkg::DIR_RST & IMPL_MASK;
    end else if (wr && wb_req_i.adr == sio_pkg::PORT_DIRECTION_OFS) begin
      port_direction_reg_r <= wmerge(port_direction_reg_r, wb_req_i.dat, wb_req_i.sel) & IMPL_MASK;
    end
  end

  // latch takes writes at its own offset and at the pin offset
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      output_latch_reg_r <= sio_pkg::ZERO16;
    end else if (wr && (wb_req_i.adr == sio_pkg::OUTPUT_LATCH_OFS || wb_req_i.adr == sio_pkg::PIN_LEVEL_OFS)) begin
      output_latch_reg_r <= wmerge(output_latch_reg_r, wb_req_i.dat, wb_req_i.sel) & IMPL_MASK;
    end
  end

  // pins sampled every cycle; a read right after a write sees the old level (software spaces them)
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_level_reg_r <= sio_pkg::ZERO16;
    end else begin
      pin_level_reg_r <= pad_i & IMPL_MASK;
    end
  end

  // plain configuration registers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      open_drain_select_reg_r <= sio_pkg::ZERO16;
      analog_pin_config_reg_r <= sio_pkg::ZERO16;
      change_irq_enable_lo_r  <= sio_pkg::ZERO16;
      change_irq_enable_hi_r  <= 5'h00;
      weak_pullup_enable_lo_r <= sio_pkg::ZERO16;
      weak_pullup_enable_hi_r <= 5'h00;
    end else if (wr) begin
      case (wb_req_i.adr)
        sio_pkg::OPEN_DRAIN_OFS: open_drain_select_reg_r <= wmerge(open_drain_select_reg_r, wb_req_i.dat, wb_req_i.sel);
        sio_pkg::ANALOG_CFG_OFS: analog_pin_config_reg_r <= wmerge(analog_pin_config_reg_r, wb_req_i.dat, wb_req_i.sel);
        sio_pkg::CHG_EN_LO_OFS:  change_irq_enable_lo_r <= wmerge(change_irq_enable_lo_r, wb_req_i.dat, wb_req_i.sel);
        sio_pkg::CHG_EN_HI_OFS: begin
          if (wb_req_i.sel[0]) begin
            change_irq_enable_hi_r <= wb_req_i.dat[4:0];
          end
        end
        sio_pkg::PULLUP_LO_OFS:  weak_pullup_enable_lo_r <= wmerge(weak_pullup_enable_lo_r, wb_req_i.dat, wb_req_i.sel);
        sio_pkg::PULLUP_HI_OFS: begin
          if (wb_req_i.sel[0]) begin
            weak_pullup_enable_hi_r <= wb_req_i.dat[4:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ***************************************************
  // pin drive
  // ***************************************************
  // an active peripheral owns the driver; an idle one hands the pin to the port.
  // input-only functions never raise drive, so such pins are pure port pins.
  assign periph_act = periph_en_i & periph_drive_i & IMPL_MASK;
  assign port_drive = ~port_direction_reg_r & ~periph_act & IMPL_MASK;
  assign drive      = periph_act | port_drive;
  assign val        = (periph_act & periph_out_i) | (~periph_act & output_latch_reg_r);

  // open drain only ever pulls low, so a 1 releases the pin
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pad_val_r  <= sio_pkg::ZERO16;
      pad_oe_n_r <= 16'hFFFF;
    end else begin
      pad_val_r  <= val & ~open_drain_select_reg_r;
      pad_oe_n_r <= ~(drive & (~open_drain_select_reg_r | ~val));
    end
  end

  assign pad_o.o    = pad_val_r;
  assign pad_o.oe_n = pad_oe_n_r;

  // ***************************************************
  // peripheral input routing and its lock
  // ***************************************************
  // unlock needs key1 then key2, then one write sets or clears the lock
  always_comb begin
    lock_st_nxt = lock_st_r;
    if (wr && wb_req_i.adr == sio_pkg::MAP_LOCK_OFS && wb_req_i.sel[0]) begin
      case (lock_st_r)
        sio_pkg::LK_IDLE: lock_st_nxt = (wb_req_i.dat[7:0] == sio_pkg::UNLOCK_KEY1) ? sio_pkg::LK_KEY1 : sio_pkg::LK_IDLE;
        sio_pkg::LK_KEY1: lock_st_nxt = (wb_req_i.dat[7:0] == sio_pkg::UNLOCK_KEY2) ? sio_pkg::LK_OPEN : sio_pkg::LK_IDLE;
        sio_pkg::LK_OPEN: lock_st_nxt = sio_pkg::LK_IDLE;
        default:          lock_st_nxt = sio_pkg::LK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_st_r  <= sio_pkg::LK_IDLE;
      map_lock_r <= sio_pkg::LOCK_RST;
    end else begin
      lock_st_r <= lock_st_nxt;
      if (lock_st_r == sio_pkg::LK_OPEN && wr && wb_req_i.adr == sio_pkg::MAP_LOCK_OFS && wb_req_i.sel[0]) begin
        map_lock_r <= wb_req_i.dat[sio_pkg::LOCK_BIT];
      end
    end
  end

  // writes while locked look normal but change nothing
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_map_r <= sio_pkg::MAP_RST;
    end else if (wr && wb_req_i.adr == sio_pkg::INPUT_MAP_OFS && !map_lock_r) begin
      input_map_r <= wmerge20(input_map_r, wb_req_i.dat, wb_req_i.sel);
    end
  end

  // a pin the port drives feeds its peripheral a zero, so no loop-through; codes past the port read zero
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      periph_in_r <= 4'h0;
    end else begin
      for (int k = 0; k < sio_pkg::MAP_N; k++) begin
        if (input_map_r[k*5+4]) begin
          periph_in_r[k] <= 1'b0;
        end else begin
          periph_in_r[k] <= pin_level_reg_r[input_map_r[k*5 +: 4]] & ~port_drive[input_map_r[k*5 +: 4]];
        end
      end
    end
  end

  // ***************************************************
  // change watch
  // ***************************************************
  // detection runs on the system clock; with the clock stopped a change is caught on restart
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cn_s1_r   <= 21'h000000;
      cn_s2_r   <= 21'h000000;
      cn_prev_r <= 21'h000000;
    end else begin
      cn_s1_r   <= change_watch_input_i;
      cn_s2_r   <= cn_s1_r;
      cn_prev_r <= cn_s2_r;
    end
  end

  assign enables  = {change_irq_enable_hi_r, change_irq_enable_lo_r};
  assign mismatch = |((cn_s2_r ^ cn_prev_r) & enables);
  assign clr_flag = wr && wb_req_i.adr == sio_pkg::CHG_STATUS_OFS && wb_req_i.sel[0] && wb_req_i.dat[sio_pkg::CHG_FLAG_BIT];

  // a change in the clearing cycle keeps the flag set
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chg_flag_r <= 1'b0;
    end else if (mismatch) begin
      chg_flag_r <= 1'b1;
    end else if (clr_flag) begin
      chg_flag_r <= 1'b0;
    end
  end

  assign change_irq_o = chg_flag_r;
  assign pullup_en_o  = {weak_pullup_enable_hi_r, weak_pullup_enable_lo_r};
  assign periph_in_o  = periph_in_r;
  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = dat_r;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence wr_pin_s;
    wr && wb_req_i.adr == sio_pkg::PIN_LEVEL_OFS && wb_req_i.sel[1:0] == 2'b11;
  endsequence
  sequence rd_pin_done_s;
    ack_r && !wb_req_i.we && wb_req_i.adr == sio_pkg::PIN_LEVEL_OFS;
  endsequence

  bus_ack_pulse_a: assert property (ack_r |=> !ack_r)
    else $error("ack held for more than one cycle");
  bus_ack_delay_a: assert property (req |=> ack_r)
    else $error("ack not given one cycle after request");
  input_release_a: assert property (1'b1 |=> ((pad_oe_n_r & $past(port_direction_reg_r & ~periph_act))
    == $past(port_direction_reg_r & ~periph_act)))
    else $error("input pin driven");
  periph_drive_a: assert property (1'b1 |=> ((~pad_oe_n_r & $past(periph_act & ~open_drain_select_reg_r))
    == $past(periph_act & ~open_drain_select_reg_r)))
    else $error("active peripheral not driving pin");
  od_high_a: assert property (1'b1 |=> ((pad_val_r & $past(open_drain_select_reg_r)) == 16'h0000))
    else $error("open drain pin driven high");
  pin_write_latch_a: assert property (wr_pin_s |=> output_latch_reg_r == ($past(wb_req_i.dat[15:0]) & IMPL_MASK))
    else $error("pin write did not reach latch");
  analog_zero_a: assert property (rd_pin_done_s |-> ((wb_dat_o[15:0] & analog_pin_config_reg_r) == 16'h0000))
    else $error("analog pin read nonzero");
  unimpl_zero_a: assert property (((port_direction_reg_r | output_latch_reg_r) & ~IMPL_MASK) == 16'h0000)
    else $error("unimplemented bit set");
  flag_set_a: assert property (mismatch |=> chg_flag_r)
    else $error("change not flagged");
  flag_clear_a: assert property (chg_flag_r && clr_flag && !mismatch |=> !chg_flag_r)
    else $error("flag not cleared");
  lock_hold_a: assert property (map_lock_r && wr && wb_req_i.adr == sio_pkg::INPUT_MAP_OFS |=> $stable(input_map_r))
    else $error("locked routing changed");
endmodule // sio_port
`default_nettype wire

//--- verification/sio_pad_model.sv
// pin-side model of the shared port: board pull-ups and external drivers
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// pad resolution
// ***************************************************
module sio_pad_model (
  input  wire sio_pkg::sio_pad_out_type pad_out_i, // block drive and enables
  input  wire logic [15:0]              ext_en_i,  // external driver active
  input  wire logic [15:0]              ext_i,     // external driver level
  output logic [15:0]                   pad_o      // resolved pin level
);
  // a released pin with no external driver rises on the board pull-up,
  // which is what an open-drain pin relies on to show a high level
  assign pad_o = (~pad_out_i.oe_n & pad_out_i.o)
               | (pad_out_i.oe_n & ~ext_en_i)
               | (pad_out_i.oe_n & ext_en_i & ext_i);
endmodule // sio_pad_model
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the shared i/o port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] MASK = 16'hBFFF; // bit 14 absent on this variant
  logic                     clock_i, resetn_i, wb_ack_o, change_irq_o;
  sio_pkg::sio_wb_req_type  req;
  sio_pkg::sio_pad_out_type pad_o;
  logic [31:0]              wb_dat_o, lfsr_r, exp_q[$];
  logic [15:0]              pad_i, pen, pdrv, pout, ext_en, ext;
  logic [3:0]               pin_o;
  logic [20:0]              watch, pu_o;
  int                       bad_count, n_compared;
  sio_port #(.IMPL_MASK(MASK)) dut (.clock_i(clock_i), .resetn_i(resetn_i), .wb_req_i(req),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pad_i(pad_i), .pad_o(pad_o), .periph_en_i(pen),
    .periph_drive_i(pdrv), .periph_out_i(pout), .periph_in_o(pin_o), .change_watch_input_i(watch),
    .pullup_en_o(pu_o), .change_irq_o(change_irq_o));
  sio_pad_model pads (.pad_out_i(pad_o), .ext_en_i(ext_en), .ext_i(ext), .pad_o(pad_i));
  // ***************************************************
  // clock, watchdog, checking
  // ***************************************************
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    bad_count++;
    summarize();
  end
  // next random value for the pin stimulus
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read data is judged against the oldest noted expectation
  always @(posedge clock_i) begin
    if (wb_ack_o === 1'b1 && req.we === 1'b0) chk("wb_dat_o", exp_q.pop_front(), wb_dat_o);
  end
  // ***************************************************
  // bus tasks
  // ***************************************************
  // request held until the edge that samples ack, then dropped for a cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clock_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    req <= '0;
    if (n >= 40) bad_count++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (change_irq_o !== 1'b1 && n < 10) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 10) bad_count++;
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  initial begin
    lfsr_r = 32'h0000FA19;
    req = '0; resetn_i = 1'b0; pen = 16'h0; pdrv = 16'h0; pout = 16'h0;
    ext_en = 16'hFF00; ext = 16'h0; watch = 21'h0; bad_count = 0; n_compared = 0;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(sio_pkg::PORT_DIRECTION_OFS, {16'h0, 16'hFFFF & MASK});
    chk("oe_n", 32'h0000FFFF, {16'h0, pad_o.oe_n});
    rd(8'h3C, 32'h0);
    // low byte as outputs; the pin register write lands in the latch
    wb(1'b1, sio_pkg::PORT_DIRECTION_OFS, 32'h0000FF00);
    wb(1'b1, sio_pkg::PIN_LEVEL_OFS, 32'h0000FFA5);
    rd(sio_pkg::OUTPUT_LATCH_OFS, {16'h0, 16'hFFA5 & MASK});
    chk("pad", 32'h00FF00A5, {8'h0, pad_o.oe_n[15:8], pad_o.oe_n[7:0], pad_o.o[7:0]});
    wb(1'b1, sio_pkg::ANALOG_CFG_OFS, 32'h00000300);
    for (int i = 0; i < 3; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      ext <= lfsr_r[15:0];
      repeat (3) @(posedge clock_i);
      rd(sio_pkg::PIN_LEVEL_OFS, {16'h0, {ext[15:8], 8'hA5} & ~16'h0300 & MASK});
    end
    // open drain: latch bits 0 and 2 high are released, 1 and 3 pulled low
    wb(1'b1, sio_pkg::OPEN_DRAIN_OFS, 32'h0000000F);
    repeat (3) @(posedge clock_i);
    chk("od", 32'h05, {24'h0, pad_o.o[3:0], pad_o.oe_n[3:0]});
    wb(1'b1, sio_pkg::OPEN_DRAIN_OFS, 32'h0);
    // pin 0 taken by a driving peripheral, pin 1 enabled but idle
    @(posedge clock_i);
    pen <= 16'h0003; pdrv <= 16'h0001; pout <= 16'h0002;
    repeat (3) @(posedge clock_i);
    chk("override", 32'h0, {28'h0, pad_o.o[1:0], pad_o.oe_n[1:0]});
    rd(sio_pkg::PIN_LEVEL_OFS, {16'h0, {ext[15:8], 8'hA4} & ~16'h0300 & MASK});
    // routing: pin 7 is port driven, pins 12 and 13 are inputs, 16 is void
    wb(1'b1, sio_pkg::INPUT_MAP_OFS, 32'h0006C187);
    repeat (4) @(posedge clock_i);
    chk("periph_in", {28'h0, ext[13], 1'b0, ext[12], 1'b0}, {28'h0, pin_o});
    // lock the routing, then a routing write must be ignored
    wb(1'b1, sio_pkg::MAP_LOCK_OFS, 32'h46);
    wb(1'b1, sio_pkg::MAP_LOCK_OFS, 32'h57);
    wb(1'b1, sio_pkg::MAP_LOCK_OFS, 32'h01);
    rd(sio_pkg::MAP_LOCK_OFS, 32'h1);
    wb(1'b1, sio_pkg::INPUT_MAP_OFS, 32'h0);
    rd(sio_pkg::INPUT_MAP_OFS, 32'h0006C187);
    // change watch: bit 5 disabled, 3, 16 and 20 enabled in both registers
    wb(1'b1, sio_pkg::CHG_EN_LO_OFS, 32'h0008);
    wb(1'b1, sio_pkg::CHG_EN_HI_OFS, 32'h11);
    watch <= watch ^ 21'h000020;
    repeat (6) @(posedge clock_i);
    chk("irq off", 32'h0, {31'h0, change_irq_o});
    foreach (pin_o[k]) begin
      if (k < 3) begin
        watch <= watch ^ (21'h1 << (k == 0 ? 3 : (k == 1 ? 16 : 20)));
        @(posedge clock_i);
        wait_irq();
        rd(sio_pkg::CHG_STATUS_OFS, 32'h1);
        wb(1'b1, sio_pkg::CHG_STATUS_OFS, 32'h1);
        rd(sio_pkg::CHG_STATUS_OFS, 32'h0);
      end
    end
    // pull-ups only on watch inputs, none of which is a port output here
    wb(1'b1, sio_pkg::PULLUP_LO_OFS, 32'h0F0F);
    wb(1'b1, sio_pkg::PULLUP_HI_OFS, 32'h15);
    chk("pullup", 32'h00150F0F, {11'h0, pu_o});
    // a second reset in mid-run returns every pin to input
    @(posedge clock_i);
    resetn_i <= 1'b0;
    // peripherals let go too, else an active one still owns pin 0
    pen <= 16'h0;
    pdrv <= 16'h0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(sio_pkg::PORT_DIRECTION_OFS, {16'h0, 16'hFFFF & MASK});
    chk("oe_n rst", 32'h0000FFFF, {16'h0, pad_o.oe_n});
    repeat (2) @(posedge clock_i);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
